// ===== design/mlsd_mac_eee.sv
// MAC speed/duplex select, full-duplex internal loopback and EEE transmit LPI control
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "mlsd_cfg.svh"
module mlsd_mac_eee
   import mlsd_pkg::*;
#(
   parameter int LINK_UP_CYC = `MLSD_LINK_UP_CYC
) (
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic [31:0] i_paddr,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [31:0] i_pwdata,
   output      logic [31:0] o_prdata,
   output      logic        o_pready,
   output      logic        o_pslverr,
   input  wire logic        i_rx_clk,
   input  wire logic        i_phy_duplex,
   input  wire logic        i_phy_link_up,
   input  wire logic        i_phy_sync,
   input  wire logic        i_eee_advertised,
   input  wire logic        i_fifo_empty,
   input  wire logic        i_resp_pending,
   input  wire mlsd_beat_s  i_tx_beat,
   output      mlsd_beat_s  o_phy_beat,
   output      mlsd_beat_s  o_loop_beat,
   output      logic        o_tx_ready,
   output      logic        o_phy_lpi,
   output      logic        o_client_lpi,
   output      logic        o_usb_irq,
   output      logic        o_usb_wakeup,
   output      logic [1:0]  o_speed,
   output      logic        o_full_duplex
);
   logic [31:0] ctrl_reg;
   logic [31:0] req_dly_reg;
   logic [31:0] rmv_dly_reg;
   logic [31:0] wake_1g_reg;
   logic [31:0] wake_100_reg;
   logic [31:0] ifg_reg;
   logic [31:0] txctrl_reg;
   logic [3:0]  status_reg;
   logic [2:0]  rxc_sync_reg;
   logic [1:0]  dpx_sync_reg;
   logic [1:0]  lnk_sync_reg;
   logic [1:0]  syn_sync_reg;
   logic        rxc_prev_reg;
   logic [7:0]  rxc_win_reg;
   logic [7:0]  rxc_edges_reg;
   logic        auto_dpx_reg;
   logic [1:0]  auto_spd_reg;
   logic        sync_prev_reg;
   logic [31:0] link_cnt_reg;
   logic        link_ok_reg;
   logic [5:0]  empty_pre_reg;
   logic [5:0]  rmv_pre_reg;
   logic [5:0]  wake_pre_reg;
   logic        empty_tick;
   logic        rmv_tick;
   logic        wake_tick;
   logic        phy_lpi_next;
   logic [31:0] empty_us_reg;
   logic [31:0] rmv_us_reg;
   logic        rmv_done_reg;
   mlsd_client_e cl_reg;
   logic        in_frame_reg;
   logic        carrier_reg;
   logic [31:0] wake_cnt_reg;
   logic [31:0] ifg_cnt_reg;
   logic        deferring_reg;
   logic        apb_wr;
   logic        apb_rd;
   logic        rxc_rise;
   logic        sync_lost;
   logic        eee_ok;
   logic        empty_expired;
   logic        rmv_expire;
   logic [1:0]  cur_speed;
   logic        cur_dpx;
   logic        tx_start;

   // APB strobes; zero wait states
   assign apb_wr = i_psel & i_penable & i_pwrite;
   assign apb_rd = i_psel & i_penable & ~i_pwrite;

   // Effective speed and duplex
   assign cur_speed = ctrl_reg[`MLSD_CTRL_ASD] ? auto_spd_reg :
                      ctrl_reg[`MLSD_CTRL_CFG_LO +: 2];
   assign cur_dpx = ctrl_reg[`MLSD_CTRL_ADD] ? auto_dpx_reg :
                    ctrl_reg[`MLSD_CTRL_DPX];

   // Input synchronisers
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rxc_sync_reg <= 3'h0;
         dpx_sync_reg <= 2'h0;
         lnk_sync_reg <= 2'h0;
         syn_sync_reg <= 2'h0;
      end else begin
         rxc_sync_reg <= {rxc_sync_reg[1:0], i_rx_clk};
         dpx_sync_reg <= {dpx_sync_reg[0], i_phy_duplex};
         lnk_sync_reg <= {lnk_sync_reg[0], i_phy_link_up};
         syn_sync_reg <= {syn_sync_reg[0], i_phy_sync};
      end
   end
   assign rxc_rise  = rxc_sync_reg[2] & ~rxc_prev_reg;
   assign sync_lost = sync_prev_reg & ~syn_sync_reg[1];

   // Speed detection: count receive clock edges in a window
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rxc_prev_reg  <= 1'b0;
         rxc_win_reg   <= 8'h00;
         rxc_edges_reg <= 8'h00;
         auto_spd_reg  <= MLSD_SPD_10;
         auto_dpx_reg  <= 1'b0;
         sync_prev_reg <= 1'b0;
      end else begin
         rxc_prev_reg  <= rxc_sync_reg[2];
         sync_prev_reg <= syn_sync_reg[1];
         if (sync_lost && ctrl_reg[`MLSD_CTRL_ASD]) begin
            rxc_win_reg   <= 8'h00;
            rxc_edges_reg <= 8'h00;
         end else if (rxc_win_reg == 8'(`MLSD_RXC_WIN_CYC - 1)) begin
            rxc_win_reg   <= 8'h00;
            rxc_edges_reg <= 8'h00;
            // Slow edge rate means 10M; sampled clock aliases at speed
            if (rxc_edges_reg == 8'h00)
               auto_spd_reg <= MLSD_SPD_10;
            else if (rxc_edges_reg < 8'h02)
               auto_spd_reg <= MLSD_SPD_100;
            else
               auto_spd_reg <= MLSD_SPD_1000;
         end else begin
            rxc_win_reg <= rxc_win_reg + 8'h01;
            if (rxc_rise)
               rxc_edges_reg <= rxc_edges_reg + 8'h01;
         end
         if (sync_lost && ctrl_reg[`MLSD_CTRL_ADD])
            auto_dpx_reg <= 1'b0;
         else
            auto_dpx_reg <= dpx_sync_reg[1];
      end
   end

   // Link up for one second qualifier
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         link_cnt_reg <= 32'h0;
         link_ok_reg  <= 1'b0;
      end else if (!lnk_sync_reg[1]) begin
         link_cnt_reg <= 32'h0;
         link_ok_reg  <= 1'b0;
      end else if (link_cnt_reg >= 32'(LINK_UP_CYC - 1)) begin
         link_ok_reg <= 1'b1;
      end else begin
         link_cnt_reg <= link_cnt_reg + 32'h1;
      end
   end

   // EEE qualifier, independent of transmitter enable
   assign eee_ok = ctrl_reg[`MLSD_CTRL_EEE] &
                   (cur_speed != 2'(MLSD_SPD_10)) & cur_dpx &
                   i_eee_advertised & link_ok_reg;

   // Microsecond prescaler per timer, so no partial time carries over
   assign empty_tick = (empty_pre_reg == 6'(`MLSD_US_CYCLES - 1));
   assign rmv_tick   = (rmv_pre_reg == 6'(`MLSD_US_CYCLES - 1));
   assign wake_tick  = (wake_pre_reg == 6'(`MLSD_US_CYCLES - 1));

   // Empty timer; response frames do not touch it
   assign empty_expired = i_fifo_empty && (empty_us_reg >= req_dly_reg);
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         empty_us_reg  <= 32'h0;
         empty_pre_reg <= 6'h0;
      end else if (!i_fifo_empty || rmv_expire || !eee_ok) begin
         empty_us_reg  <= 32'h0;
         empty_pre_reg <= 6'h0;
      end else if (!empty_expired) begin
         empty_pre_reg <= empty_tick ? 6'h0 : empty_pre_reg + 6'h1;
         if (empty_tick)
            empty_us_reg <= empty_us_reg + 32'h1;
      end
   end

   // Auto removal timer runs while client wants LPI
   assign rmv_expire = ctrl_reg[`MLSD_CTRL_RMV_EN] &&
                       (cl_reg != MLSD_CL_WAIT) &&
                       rmv_us_reg >= rmv_dly_reg && !rmv_done_reg;
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rmv_us_reg   <= 32'h0;
         rmv_pre_reg  <= 6'h0;
         rmv_done_reg <= 1'b0;
      end else if (cl_reg == MLSD_CL_WAIT) begin
         rmv_us_reg   <= 32'h0;
         rmv_pre_reg  <= 6'h0;
         rmv_done_reg <= 1'b0;
      end else if (rmv_expire) begin
         rmv_done_reg <= 1'b1;
      end else begin
         rmv_pre_reg <= rmv_tick ? 6'h0 : rmv_pre_reg + 6'h1;
         if (rmv_tick)
            rmv_us_reg <= rmv_us_reg + 32'h1;
      end
   end

   // Client request machine; HOLD is a response frame drop
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         cl_reg <= MLSD_CL_WAIT;
      end else begin
         unique case (cl_reg)
            MLSD_CL_WAIT: begin
               if (empty_expired && eee_ok && !in_frame_reg)
                  cl_reg <= MLSD_CL_REQ;
            end
            MLSD_CL_REQ: begin
               if (!empty_expired || !eee_ok || rmv_expire)
                  cl_reg <= MLSD_CL_WAIT;
               else if (i_resp_pending)
                  cl_reg <= MLSD_CL_HOLD;
            end
            MLSD_CL_HOLD: begin
               if (!empty_expired || !eee_ok || rmv_expire)
                  cl_reg <= MLSD_CL_WAIT;
               else if (!i_resp_pending)
                  cl_reg <= MLSD_CL_REQ;
            end
         endcase
      end
   end

   // Client request output, registered
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst)
         o_client_lpi <= 1'b0;
      else
         o_client_lpi <= (cl_reg == MLSD_CL_REQ);
   end

   // Frame tracking and PHY request; request is registered and follows the client state outside a frame
   assign tx_start = i_tx_beat.valid && !in_frame_reg && !deferring_reg;
   // Request held through a frame, so a mid-frame blip is ignored
   assign phy_lpi_next = in_frame_reg ? o_phy_lpi :
                         (cl_reg == MLSD_CL_REQ);
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         in_frame_reg <= 1'b0;
         o_phy_lpi    <= 1'b0;
      end else begin
         if (i_tx_beat.valid && o_tx_ready && i_tx_beat.last)
            in_frame_reg <= 1'b0;
         else if (tx_start)
            in_frame_reg <= 1'b1;
         o_phy_lpi <= phy_lpi_next;
      end
   end

   // Carrier indicator and wake timer
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         carrier_reg  <= 1'b0;
         wake_cnt_reg <= 32'h0;
         wake_pre_reg <= 6'h0;
      end else if (o_phy_lpi) begin
         carrier_reg  <= 1'b1;
         wake_cnt_reg <= (cur_speed == 2'(MLSD_SPD_1000)) ?
                         wake_1g_reg : wake_100_reg;
         wake_pre_reg <= 6'h0;
      end else if (carrier_reg) begin
         if (wake_cnt_reg == 32'h0) begin
            carrier_reg <= 1'b0;
         end else begin
            wake_pre_reg <= wake_tick ? 6'h0 : wake_pre_reg + 6'h1;
            if (wake_tick)
               wake_cnt_reg <= wake_cnt_reg - 32'h1;
         end
      end
   end

   // Deferral with inter-frame gap
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         deferring_reg <= 1'b0;
         ifg_cnt_reg   <= 32'h0;
      end else if (in_frame_reg || carrier_reg || tx_start) begin
         deferring_reg <= 1'b1;
         ifg_cnt_reg   <= ifg_reg;
      end else if (deferring_reg) begin
         if (ifg_cnt_reg == 32'h0)
            deferring_reg <= 1'b0;
         else
            ifg_cnt_reg <= ifg_cnt_reg - 32'h1;
      end
   end

   // Data path: PHY, or loopback which drops beats in half duplex; stalls while deferring
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_phy_beat  <= '0;
         o_loop_beat <= '0;
         o_tx_ready  <= 1'b0;
      end else begin
         o_tx_ready <= (in_frame_reg || !deferring_reg) && !phy_lpi_next &&
                       txctrl_reg[0];
         o_phy_beat  <= '0;
         o_loop_beat <= '0;
         if (i_tx_beat.valid && o_tx_ready) begin
            if (ctrl_reg[`MLSD_CTRL_LOOP] && cur_dpx)
               o_loop_beat <= i_tx_beat;
            else if (!ctrl_reg[`MLSD_CTRL_LOOP])
               o_phy_beat <= i_tx_beat;
         end
      end
   end

   // Sticky status flags; hardware set wins over software clear
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         status_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (apb_wr && i_paddr[11:0] == `MLSD_OFS_STATUS && i_pwdata[i])
               status_reg[i] <= 1'b0;
         end
         if (cl_reg == MLSD_CL_WAIT && empty_expired && eee_ok &&
             !in_frame_reg)
            status_reg[`MLSD_ST_START] <= 1'b1;
         if (rmv_expire) begin
            status_reg[`MLSD_ST_STOP] <= 1'b1;
            if (ctrl_reg[`MLSD_CTRL_WAKE_EN]) begin
               status_reg[`MLSD_ST_WAKE] <= 1'b1;
               status_reg[`MLSD_ST_WUPS] <= 1'b1;
            end
         end
      end
   end

   // USB interrupt and remote wakeup outputs
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_usb_irq    <= 1'b0;
         o_usb_wakeup <= 1'b0;
      end else begin
         o_usb_irq <= (status_reg[`MLSD_ST_START] &
                       ctrl_reg[`MLSD_CTRL_START_EN]) |
                      (status_reg[`MLSD_ST_STOP] &
                       ctrl_reg[`MLSD_CTRL_STOP_EN]);
         o_usb_wakeup <= status_reg[`MLSD_ST_WUPS] &
                         ctrl_reg[`MLSD_CTRL_WUP_EN];
      end
   end

   // Register writes; auto fields report detected values
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_reg     <= `MLSD_CTRL_RESET;
         req_dly_reg  <= 32'h0;
         rmv_dly_reg  <= 32'h0;
         wake_1g_reg  <= 32'h0;
         wake_100_reg <= 32'h0;
         ifg_reg      <= `MLSD_IFG_RESET;
         txctrl_reg   <= 32'h0;
      end else begin
         if (apb_wr) begin
            unique case (i_paddr[11:0])
               `MLSD_OFS_CTRL:     ctrl_reg     <= i_pwdata;
               `MLSD_OFS_REQ_DLY:  req_dly_reg  <= i_pwdata;
               `MLSD_OFS_RMV_DLY:  rmv_dly_reg  <= i_pwdata;
               `MLSD_OFS_WAKE_1G:  wake_1g_reg  <= i_pwdata;
               `MLSD_OFS_WAKE_100: wake_100_reg <= i_pwdata;
               `MLSD_OFS_IFG:      ifg_reg      <= i_pwdata;
               `MLSD_OFS_TXCTRL:   txctrl_reg   <= i_pwdata;
               default: ;
            endcase
         end else begin
            if (ctrl_reg[`MLSD_CTRL_ASD])
               ctrl_reg[`MLSD_CTRL_CFG_LO +: 2] <= auto_spd_reg;
            if (ctrl_reg[`MLSD_CTRL_ADD])
               ctrl_reg[`MLSD_CTRL_DPX] <= auto_dpx_reg;
         end
      end
   end

   // Read data and response
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_prdata  <= 32'h0;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= i_psel & ~i_penable;
         o_pslverr <= 1'b0;
         if (i_psel && !i_penable) begin
            unique case (i_paddr[11:0])
               `MLSD_OFS_CTRL:     o_prdata <= ctrl_reg;
               `MLSD_OFS_STATUS:   o_prdata <= {28'h0, status_reg};
               `MLSD_OFS_REQ_DLY:  o_prdata <= req_dly_reg;
               `MLSD_OFS_RMV_DLY:  o_prdata <= rmv_dly_reg;
               `MLSD_OFS_WAKE_1G:  o_prdata <= wake_1g_reg;
               `MLSD_OFS_WAKE_100: o_prdata <= wake_100_reg;
               `MLSD_OFS_IFG:      o_prdata <= ifg_reg;
               `MLSD_OFS_TXCTRL:   o_prdata <= txctrl_reg;
               default: begin
                  o_prdata  <= 32'h0;
                  o_pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // Speed and duplex outputs
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_speed       <= 2'h0;
         o_full_duplex <= 1'b0;
      end else begin
         o_speed       <= cur_speed;
         o_full_duplex <= cur_dpx;
      end
   end
endmodule : mlsd_mac_eee

// ===== design/mlsd_cfg.svh
// Offsets, field positions, reset values and timing counts for the MAC EEE block
`ifndef MLSD_CFG_SVH
`define MLSD_CFG_SVH
`define MLSD_OFS_CTRL       12'h000
`define MLSD_OFS_STATUS     12'h004
`define MLSD_OFS_REQ_DLY    12'h008
`define MLSD_OFS_RMV_DLY    12'h00c
`define MLSD_OFS_WAKE_1G    12'h010
`define MLSD_OFS_WAKE_100   12'h014
`define MLSD_OFS_IFG        12'h018
`define MLSD_OFS_TXCTRL     12'h01c
`define MLSD_CTRL_DPX       0
`define MLSD_CTRL_CFG_LO    1
`define MLSD_CTRL_ASD       3
`define MLSD_CTRL_ADD       4
`define MLSD_CTRL_LOOP      5
`define MLSD_CTRL_EEE       6
`define MLSD_CTRL_RMV_EN    7
`define MLSD_CTRL_START_EN  8
`define MLSD_CTRL_STOP_EN   9
`define MLSD_CTRL_WAKE_EN   10
`define MLSD_CTRL_WUP_EN    11
`define MLSD_ST_START       0
`define MLSD_ST_STOP        1
`define MLSD_ST_WAKE        2
`define MLSD_ST_WUPS        3
`define MLSD_CTRL_RESET     32'h0000_0000
`define MLSD_IFG_RESET      32'h0000_000c
`define MLSD_CLK_MHZ        50
`define MLSD_US_CYCLES      (`MLSD_CLK_MHZ)
`define MLSD_LINK_UP_US     1000000
`define MLSD_LINK_UP_CYC    (`MLSD_LINK_UP_US * `MLSD_CLK_MHZ)
`define MLSD_RXC_WIN_CYC    16
`endif

// ===== design/mlsd_pkg.sv
// Types shared by the MAC EEE, speed, duplex and loopback block
package mlsd_pkg;
   typedef enum logic [1:0] {
      MLSD_SPD_10   = 2'h0,
      MLSD_SPD_100  = 2'h1,
      MLSD_SPD_1000 = 2'h2
   } mlsd_speed_e;
   typedef enum logic [2:0] {
      MLSD_CL_WAIT  = 3'h1,
      MLSD_CL_REQ   = 3'h2,
      MLSD_CL_HOLD  = 3'h4
   } mlsd_client_e;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } mlsd_beat_s;
   typedef struct packed {
      logic [31:0] addr;
      logic        sel;
      logic        enable;
      logic        write;
      logic [31:0] wdata;
   } mlsd_apb_s;
endpackage : mlsd_pkg

// ===== tb/mlsd_mac_eee_properties.sv
// Port-level concurrent checks for the MAC EEE block
`timescale 1ns/1ns
module mlsd_mac_eee_properties
   import mlsd_pkg::*;
(
   input wire logic       i_clock,
   input wire logic       i_nrst,
   input wire logic       i_psel,
   input wire logic       i_penable,
   input wire logic       i_fifo_empty,
   input wire mlsd_beat_s i_tx_beat,
   input wire logic       o_pready,
   input wire logic       o_pslverr,
   input wire mlsd_beat_s o_phy_beat,
   input wire mlsd_beat_s o_loop_beat,
   input wire logic       o_tx_ready,
   input wire logic       o_phy_lpi,
   input wire logic       o_client_lpi,
   input wire logic [1:0] o_speed,
   input wire logic       o_full_duplex
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // Transmitter stays closed for 8 cycles after the PHY request falls
   sequence s_wake_hold;
      !o_tx_ready [*8];
   endsequence
   // Bus answer timing
   bus_answer_a: assert property (i_psel && i_penable |-> o_pready)
      else $error("no answer in access cycle");
   ready_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("ready held past one cycle");
   err_with_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");
   // Low power request and its effect on the transmitter
   lpi_terms_a: assert property (
      o_client_lpi |-> o_full_duplex && o_speed != 2'h0)
      else $error("request outside allowed mode");
   phy_follows_a: assert property (
      $rose(o_phy_lpi) |-> o_client_lpi)
      else $error("phy request without client request");
   fifo_drops_a: assert property (
      o_client_lpi && !i_fifo_empty |-> ##[1:3] !o_client_lpi)
      else $error("request kept with data waiting");
   lpi_blocks_tx_a: assert property (o_phy_lpi |-> !o_tx_ready)
      else $error("transmitter open during low power");
   wake_defer_a: assert property ($fell(o_phy_lpi) |-> s_wake_hold)
      else $error("frame started before wake time");
   // Data path
   beat_out_a: assert property (
      i_tx_beat.valid && o_tx_ready |=> (o_phy_beat.valid ?
      o_phy_beat.data : o_loop_beat.data) == $past(i_tx_beat.data))
      else $error("accepted beat not forwarded");
   loop_not_phy_a: assert property (
      o_loop_beat.valid |-> !o_phy_beat.valid)
      else $error("looped beat also sent to phy");
endmodule : mlsd_mac_eee_properties

bind mlsd_mac_eee mlsd_mac_eee_properties u_props (
   .i_clock, .i_nrst, .i_psel, .i_penable, .i_fifo_empty, .i_tx_beat,
   .o_pready, .o_pslverr, .o_phy_beat, .o_loop_beat, .o_tx_ready,
   .o_phy_lpi, .o_client_lpi, .o_speed, .o_full_duplex);

// ===== tb/mlsd_phy_model.sv
// Behavioural external PHY: receive clock, duplex pin, beat count
`timescale 1ns/1ns
module mlsd_phy_model
   import mlsd_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_run,
   input  wire logic       i_full,
   input  wire mlsd_beat_s i_beat,
   output      logic       o_rx_clk,
   output      logic       o_duplex,
   output      int         o_beats
);
   // Receive clock, unrelated in phase, stopped while i_run is low
   initial begin
      o_rx_clk = 1'b0;
      #7;
      forever #80 o_rx_clk = i_run ? ~o_rx_clk : 1'b0;
   end
   // Duplex status pin
   assign o_duplex = i_full;
   // Count beats driven towards the wire
   initial o_beats = 0;
   always @(posedge i_clock) begin
      if (i_beat.valid === 1'b1)
         o_beats <= o_beats + 1;
   end
endmodule : mlsd_phy_model

// ===== tb/mlsd_mac_eee_tb_top.sv
// Self-checking bench for the MAC speed, loopback and EEE block
`timescale 1ns/1ns
`include "mlsd_cfg.svh"
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
   n_errors++; $display("BAD %s exp %h got %h", nm, (exp), (got)); end end
module mlsd_mac_eee_tb_top
   import mlsd_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prd;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic        perr;
   logic        run = 1'b1;
   logic        full = 1'b1;
   logic        sync = 1'b1;
   logic        link = 1'b1;
   logic        adv = 1'b1;
   logic        empty = 1'b0;
   logic        resp = 1'b0;
   mlsd_beat_s  beat = '0;
   logic [31:0] prdata;
   logic        pready, pslverr, rx_clk, duplex_mode_bit, tx_ready, phy_lpi, cl_lpi;
   logic        irq, wup, fd;
   logic [1:0]  speed;
   mlsd_beat_s  phy_beat, loop_beat;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          nb;
   int          n;

   // Design with a short link-up qualification
   mlsd_mac_eee #(.LINK_UP_CYC(100)) dut (
      .i_clock(clk), .i_nrst(nrst), .i_paddr(paddr), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_rx_clk(rx_clk), .i_phy_duplex(duplex_mode_bit), .i_phy_link_up(link),
      .i_phy_sync(sync), .i_eee_advertised(adv), .i_fifo_empty(empty),
      .i_resp_pending(resp), .i_tx_beat(beat), .o_phy_beat(phy_beat),
      .o_loop_beat(loop_beat), .o_tx_ready(tx_ready),
      .o_phy_lpi(phy_lpi), .o_client_lpi(cl_lpi), .o_usb_irq(irq),
      .o_usb_wakeup(wup), .o_speed(speed), .o_full_duplex(fd));
   mlsd_phy_model u_phy (
      .i_clock(clk), .i_run(run), .i_full(full), .i_beat(phy_beat),
      .o_rx_clk(rx_clk), .o_duplex(duplex_mode_bit), .o_beats(nb));

   // Clock and hang limit
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end

   // One bus transfer, waits for the slave's answer
   task automatic apb(input logic w, input logic [31:0] a, d);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      prd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge clk);
   endtask : apb

   // Count cycles until the client request reaches a level
   task automatic wait_cl(input logic lvl, input int lim);
      for (n = 0; n < lim && cl_lpi !== lvl; n++) @(posedge clk);
   endtask : wait_cl

   // Offer one single-byte frame
   task automatic send(input logic [7:0] d);
      beat <= '{valid: 1'b1, data: d, last: 1'b1};
      @(posedge clk);
      while (tx_ready !== 1'b1) @(posedge clk);
      beat <= '0;
      @(posedge clk);
   endtask : send

   task automatic t_regs();
      apb(1'b0, `MLSD_OFS_CTRL, 32'h0);
      `CHK("ctrl reset", `MLSD_CTRL_RESET, prd)
      apb(1'b0, `MLSD_OFS_IFG, 32'h0);
      `CHK("ifg reset", `MLSD_IFG_RESET, prd)
      apb(1'b0, 32'h40, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {perr, prd})
      apb(1'b1, `MLSD_OFS_REQ_DLY, 32'h1);
      apb(1'b1, `MLSD_OFS_WAKE_1G, 32'h1);
      apb(1'b0, `MLSD_OFS_REQ_DLY, 32'h0);
      `CHK("req dly", 32'h1, prd)
      $display("test regs done");
   endtask : t_regs

   task automatic t_speed();
      apb(1'b1, `MLSD_OFS_CTRL, 32'h5);
      @(posedge clk);
      `CHK("man speed", 2'h2, speed)
      `CHK("man dpx", 1'b1, fd)
      full <= 1'b0;
      apb(1'b1, `MLSD_OFS_CTRL, 32'h19);
      repeat (60) @(posedge clk);
      `CHK("auto speed", 2'h2, speed)
      `CHK("auto dpx", 1'b0, fd)
      apb(1'b0, `MLSD_OFS_CTRL, 32'h0);
      `CHK("reported", 3'h4, prd[2:0])
      run <= 1'b0;
      full <= 1'b1;
      sync <= 1'b0;
      repeat (60) @(posedge clk);
      sync <= 1'b1;
      repeat (60) @(posedge clk);
      `CHK("resync speed", 2'h0, speed)
      `CHK("resync dpx", 1'b1, fd)
      run <= 1'b1;
      $display("test speed done");
   endtask : t_speed

   task automatic t_lpi();
      apb(1'b1, `MLSD_OFS_CTRL, 32'h5);
      empty <= 1'b1;
      repeat (200) @(posedge clk);
      `CHK("eee off", 1'b0, cl_lpi)
      empty <= 1'b0;
      apb(1'b1, `MLSD_OFS_CTRL, 32'h145);
      empty <= 1'b1;
      repeat (30) @(posedge clk);
      empty <= 1'b0;
      @(posedge clk);
      empty <= 1'b1;
      wait_cl(1'b1, 300);
      `CHK("empty delay", 1'b1, n >= 49 && n <= 58)
      repeat (2) @(posedge clk);
      `CHK("phy lpi", 1'b1, phy_lpi)
      apb(1'b0, `MLSD_OFS_STATUS, 32'h0);
      `CHK("start flag", 1'b1, prd[`MLSD_ST_START])
      `CHK("start irq", 1'b1, irq)
      `CHK("lpi no transmitter_enable", 1'b1, cl_lpi)
      resp <= 1'b1;
      wait_cl(1'b0, 5);
      `CHK("resp drops", 1'b0, cl_lpi)
      resp <= 1'b0;
      wait_cl(1'b1, 5);
      `CHK("resp resumes", 1'b1, cl_lpi)
      apb(1'b1, `MLSD_OFS_TXCTRL, 32'h1);
      empty <= 1'b0;
      wait_cl(1'b0, 5);
      `CHK("fill drops", 1'b0, cl_lpi)
      for (n = 0; n < 500 && tx_ready !== 1'b1; n++) @(posedge clk);
      `CHK("wake gap", 1'b1, n >= 62 && n < 500)
      send(8'ha5);
      `CHK("tx beat", 10'h34b, phy_beat)
      @(posedge clk);
      `CHK("phy count", 1, nb)
      apb(1'b1, `MLSD_OFS_STATUS, 32'hf);
      @(posedge clk);
      `CHK("irq clear", 1'b0, irq)
      $display("test lpi done");
   endtask : t_lpi

   task automatic t_rmv();
      apb(1'b1, `MLSD_OFS_RMV_DLY, 32'h1);
      apb(1'b1, `MLSD_OFS_CTRL, 32'hfc5);
      empty <= 1'b1;
      wait_cl(1'b1, 300);
      wait_cl(1'b0, 300);
      `CHK("auto removed", 1'b0, cl_lpi)
      wait_cl(1'b1, 300);
      `CHK("rewait", 1'b1, n >= 45 && n <= 60)
      apb(1'b0, `MLSD_OFS_STATUS, 32'h0);
      `CHK("stop wake", 4'hf, prd[3:0])
      `CHK("stop irq", 1'b1, irq)
      `CHK("wakeup", 1'b1, wup)
      empty <= 1'b0;
      apb(1'b1, `MLSD_OFS_STATUS, 32'hf);
      $display("test removal done");
   endtask : t_rmv

   task automatic t_loop();
      apb(1'b1, `MLSD_OFS_CTRL, 32'h25);
      send(8'h3c);
      `CHK("loop beat", 10'h279, loop_beat)
      `CHK("phy quiet", 1'b0, phy_beat.valid)
      `CHK("phy count", 1, nb)
      $display("test loop done");
   endtask : t_loop

   // Verdict and end of run
   task automatic results();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs();
      t_speed();
      t_lpi();
      t_rmv();
      t_loop();
      results();
   end
endmodule : mlsd_mac_eee_tb_top
